// [ccra_regs.vh]
`ifndef CCRA_REGS_VH
`define CCRA_REGS_VH
// Object indices and command bytes
`define CCRA_IDX_NODE 16'h4500
`define CCRA_IDX_TERM 16'h4501
`define CCRA_CMD_DL 8'h23
`define CCRA_CMD_UL 8'h40
`define CCRA_CMD_DL_ACK 8'h60
`define CCRA_CMD_UL_ACK 8'h43
`define CCRA_CMD_UL_ACK1 8'h4F
`define CCRA_CMD_ABORT 8'h80
`define CCRA_COBID_RX 11'h600
`define CCRA_COBID_TX 11'h580
// Access word fields
`define CCRA_ACC_BIT 31
`define CCRA_TBL_HI 30
`define CCRA_TBL_LO 24
`define CCRA_REG_HI 23
`define CCRA_REG_LO 16
`define CCRA_WRITE_FLAG 8'h80
// Tables and registers
`define CCRA_TBL_CFG 7'h00
`define CCRA_TBL_ID 7'h09
`define CCRA_TBL_UNLOCK 7'h63
`define CCRA_TBL_BAUD 7'h64
`define CCRA_REG_0 8'h00
`define CCRA_REG_1 8'h01
`define CCRA_REG_2 8'h02
`define CCRA_REG_3 8'h03
`define CCRA_KEY_STEP1 16'hAFFE
`define CCRA_KEY_STEP2 16'h0001
`define CCRA_KEY_STEP3 16'h0101
// Reset values and writable masks
`define CCRA_BUSCFG_RST 16'h0006
`define CCRA_BUSCFG_MASK 16'h0007
`define CCRA_PIDESC_RST 16'h0903
`define CCRA_PIDESC_MASK 16'h0F2F
`define CCRA_BAUD_RST 16'h0004
// Field positions
`define CCRA_CFG_AUTORST 0
`define CCRA_CFG_DIAG 1
`define CCRA_CFG_DISP 2
`define CCRA_PI_EVAL 2
`define CCRA_PI_ORDER 3
`define CCRA_PI_ALIGN 5
`define CCRA_PI_LINK_LO 8
`define CCRA_PI_LINK_HI 9
`define CCRA_PI_INT_LO 10
`define CCRA_PI_INT_HI 11
// Reaction codes
`define CCRA_REACT_0 2'h0
`define CCRA_REACT_1 2'h1
`define CCRA_REACT_2 2'h2
// Abort codes
`define CCRA_AB_NOOBJ 32'h0602_0000
`define CCRA_AB_NOSUB 32'h0609_0011
`define CCRA_AB_RO 32'h0601_0002
`define CCRA_AB_ACCESS 32'h0800_0020
`define CCRA_AB_CMD 32'h0504_0001
// Timing
`define CCRA_RESTART_NS 1000000
`define CCRA_CLK_NS 10
`endif

// [ccra_sdo_frame.v]
`timescale 1ns/1ps
`include "ccra_regs.vh"
// Splits an 8-byte request into fields; builds the 8-byte reply
module ccra_sdo_frame
(
  // Request bytes
  input wire [63:0] rx_data_i,
  // Reply fields
  input wire [7:0] tx_cmd_i,
  input wire [15:0] tx_index_i,
  input wire [7:0] tx_sub_i,
  input wire [31:0] tx_word_i,
  // Decoded request
  output wire [7:0] rx_cmd_o,
  output wire [15:0] rx_index_o,
  output wire [7:0] rx_sub_o,
  output wire [31:0] rx_word_o,
  // Reply bytes
  output wire [63:0] tx_data_o
);
  // Byte 0 is the command, index low byte first, word LSB first
  assign rx_cmd_o = rx_data_i[7:0];
  assign rx_index_o = {rx_data_i[23:16], rx_data_i[15:8]};
  assign rx_sub_o = rx_data_i[31:24];
  assign rx_word_o = rx_data_i[63:32];
  assign tx_data_o = {tx_word_i, tx_sub_i, tx_index_i[15:8],
    tx_index_i[7:0], tx_cmd_i};
endmodule // ccra_sdo_frame

// [ccra_top.v]
// What this block does
// - Node tables stay write-protected until unlock completes; terminal writes via 0x4501 are not gated
// - Access word: table+0x80, register, 16-bit value
// - Table 100 reg 3 holds baud index
// - Table 9: station id, then slot ids
// - Digital id: bit15, width, direction bits
// - Extension box ids 0x000A,0x0011,0x0014,0x0015
// - Bus configuration resets to 0x0006
// - Auto-restart flag retries internal bus cyclically
// - Diagnostics flag enables emergency fault reports
// - Diag bits mapped only if display and diagnostics
// - Process image description resets to 0x0903
// - Internal fault reaction 1 zeroes inputs
// - Link loss reaction: stop, zero, or hold
// - Alignment flag puts data on even bytes
// - Byte-order flag selects little or big endian
// - Evaluation flag maps control/status bytes too
// - Terminal object subindex 0 counts terminals
// - Subindices 1..0xFE give terminal register access
// - Read: address write, access bit busy, poll
// - Value bytes ignored when access bit clear
// - Failed access answered with abort code, except node reads of unknown registers, which return 0
`timescale 1ns/1ps
`include "ccra_regs.vh"
module ccra_top
#(
  parameter NODE_ID = 7'h01,
  parameter STATION_ID = 16'h0001, // Arbitrary value
  parameter RESTART_CYCLES = `CCRA_RESTART_NS / `CCRA_CLK_NS
)
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Request frame
  input wire rx_valid_i,
  input wire [10:0] rx_cobid_i,
  input wire [63:0] rx_data_i,
  // Reply frame
  output reg tx_valid_o,
  output reg [10:0] tx_cobid_o,
  output reg [63:0] tx_data_o,
  // Slot population
  input wire [7:0] term_count_i,
  input wire [15:0] slot_id_i,
  output reg [7:0] slot_sel_o,
  // Terminal register port
  output reg term_req_o,
  output reg term_we_o,
  output reg [7:0] term_slot_o,
  output reg [6:0] term_chan_o,
  output reg [7:0] term_reg_o,
  output reg [15:0] term_wdata_o,
  input wire term_ack_i,
  input wire term_err_i,
  input wire [15:0] term_rdata_i,
  // Internal bus status and controls
  input wire int_bus_fault_i,
  input wire link_loss_i,
  input wire term_fault_i,
  output reg int_bus_restart_o,
  output reg emcy_req_o,
  output reg diag_map_o,
  output reg zero_inputs_o,
  output reg send_zero_pdo_o,
  output reg stop_cycles_o,
  output reg zero_outputs_o,
  output reg restore_outputs_o,
  output reg word_align_o,
  output reg big_endian_o,
  output reg full_eval_o,
  output reg [3:0] baud_index_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_REPLY = 3'b100;
  localparam [1:0] UL_NONE = 2'b00;
  localparam [1:0] UL_ONE = 2'b01;
  localparam [1:0] UL_TWO = 2'b10;

  wire [7:0] req_cmd;
  wire [15:0] req_index;
  wire [7:0] req_sub;
  wire [31:0] req_word;
  wire [63:0] frame_out;
  reg [7:0] ans_cmd_reg;
  reg [15:0] ans_index_reg;
  reg [7:0] ans_sub_reg;
  reg [31:0] ans_word_reg;
  reg [2:0] state_reg;
  reg [1:0] unlock_reg;
  reg [15:0] bus_cfg_reg;
  reg [15:0] pi_desc_reg;
  reg [15:0] baud_reg;
  reg [31:0] node_addr_reg;
  reg [15:0] node_data_reg;
  reg node_busy_reg;
  reg [31:0] slot_addr_reg [1:254];
  reg [15:0] slot_data_reg [1:254];
  reg [254:1] slot_busy_reg;
  reg [31:0] restart_cnt_reg;
  reg [7:0] pend_sub_reg;
  reg prev_fault_reg;
  reg prev_link_reg;

  ccra_sdo_frame u_frame
  (
    .rx_data_i(rx_data_i),
    .tx_cmd_i(ans_cmd_reg),
    .tx_index_i(ans_index_reg),
    .tx_sub_i(ans_sub_reg),
    .tx_word_i(ans_word_reg),
    .rx_cmd_o(req_cmd),
    .rx_index_o(req_index),
    .rx_sub_o(req_sub),
    .rx_word_o(req_word),
    .tx_data_o(frame_out)
  );

  // Access word field accessors
  function [6:0] acc_table;
    input [31:0] w;
    begin
      acc_table = w[`CCRA_TBL_HI:`CCRA_TBL_LO];
    end
  endfunction

  function [7:0] acc_reg;
    input [31:0] w;
    begin
      acc_reg = w[`CCRA_REG_HI:`CCRA_REG_LO];
    end
  endfunction

  // Local node register read; bit 16 flags an unknown register
  function [16:0] node_read;
    input [6:0] tbl;
    input [7:0] rg;
    input [15:0] cfg;
    input [15:0] pid;
    input [15:0] bd;
    input [15:0] sid;
    begin
      node_read = {1'b1, 16'h0000};
      if (tbl == `CCRA_TBL_ID && rg == `CCRA_REG_0)
        node_read = {1'b0, STATION_ID[15:0]};
      else if (tbl == `CCRA_TBL_ID)
        node_read = {1'b0, sid};
      else if (tbl == `CCRA_TBL_CFG && rg == `CCRA_REG_2)
        node_read = {1'b0, cfg};
      else if (tbl == `CCRA_TBL_CFG && rg == `CCRA_REG_3)
        node_read = {1'b0, pid};
      else if (tbl == `CCRA_TBL_BAUD && rg == `CCRA_REG_3)
        node_read = {1'b0, bd};
    end
  endfunction

  wire req_for_me = rx_valid_i &&
    (rx_cobid_i == (`CCRA_COBID_RX | {4'h0, NODE_ID[6:0]}));
  wire is_dl = (req_cmd == `CCRA_CMD_DL);
  wire is_ul = (req_cmd == `CCRA_CMD_UL);
  wire w_acc = req_word[`CCRA_ACC_BIT];
  wire [6:0] w_tbl = acc_table(req_word);
  wire [7:0] w_rg = acc_reg(req_word);
  wire [15:0] w_val = req_word[15:0];
  wire unlocked = (unlock_reg == 2'b11);
  wire sub_ok = (req_sub != 8'h00) && (req_sub != 8'hFF);
  wire [16:0] rd_node = node_read(acc_table(node_addr_reg),
    acc_reg(node_addr_reg), bus_cfg_reg, pi_desc_reg, baud_reg,
    slot_id_i);
  wire restart_tick = (restart_cnt_reg == RESTART_CYCLES - 1);

  // SDO command handling
  integer i;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      unlock_reg <= 2'b00;
      bus_cfg_reg <= `CCRA_BUSCFG_RST;
      pi_desc_reg <= `CCRA_PIDESC_RST;
      baud_reg <= `CCRA_BAUD_RST;
      node_addr_reg <= 32'h0000_0000;
      node_data_reg <= 16'h0000;
      node_busy_reg <= 1'b0;
      slot_busy_reg <= {254{1'b0}};
      for (i = 1; i < 255; i = i + 1)
      begin
        slot_addr_reg[i] <= 32'h0000_0000;
        slot_data_reg[i] <= 16'h0000;
      end
      ans_cmd_reg <= 8'h00;
      ans_index_reg <= 16'h0000;
      ans_sub_reg <= 8'h00;
      ans_word_reg <= 32'h0000_0000;
      tx_valid_o <= 1'b0;
      tx_cobid_o <= 11'h000;
      tx_data_o <= 64'h0000_0000_0000_0000;
      term_req_o <= 1'b0;
      term_we_o <= 1'b0;
      term_slot_o <= 8'h00;
      term_chan_o <= 7'h00;
      term_reg_o <= 8'h00;
      term_wdata_o <= 16'h0000;
      pend_sub_reg <= 8'h00;
      slot_sel_o <= 8'h00;
    end
    else
    begin
      tx_valid_o <= 1'b0;
      // Node read data settles one cycle after the address write
      if (node_busy_reg)
      begin
        node_data_reg <= rd_node[15:0];
        node_busy_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE:
        begin
          if (req_for_me)
          begin
            ans_index_reg <= req_index;
            ans_sub_reg <= req_sub;
            ans_word_reg <= 32'h0000_0000;
            ans_cmd_reg <= `CCRA_CMD_DL_ACK;
            state_reg <= ST_REPLY;
            if (!is_dl && !is_ul)
            begin
              ans_cmd_reg <= `CCRA_CMD_ABORT;
              ans_word_reg <= `CCRA_AB_CMD;
            end
            else if (req_index == `CCRA_IDX_NODE)
            begin
              if (req_sub != 8'h00)
              begin
                ans_cmd_reg <= `CCRA_CMD_ABORT;
                ans_word_reg <= `CCRA_AB_NOSUB;
              end
              else if (is_ul)
              begin
                ans_cmd_reg <= `CCRA_CMD_UL_ACK;
                ans_word_reg <= {node_busy_reg, node_addr_reg[30:16],
                  node_data_reg};
              end
              else if (!w_acc)
              begin
                node_addr_reg <= {1'b0, req_word[30:16], 16'h0000};
                node_busy_reg <= 1'b1;
                slot_sel_o <= w_rg;
              end
              else if (w_tbl == `CCRA_TBL_UNLOCK)
              begin
                // Wrong step restarts the sequence; unlock holds till reset
                if (unlocked)
                  unlock_reg <= 2'b11;
                else if (w_rg == `CCRA_REG_2 && w_val == `CCRA_KEY_STEP1)
                  unlock_reg <= UL_ONE;
                else if (unlock_reg == UL_ONE && w_rg == `CCRA_REG_1 &&
                  w_val == `CCRA_KEY_STEP2)
                  unlock_reg <= UL_TWO;
                else if (unlock_reg == UL_TWO && w_rg == `CCRA_REG_0 &&
                  w_val == `CCRA_KEY_STEP3)
                  unlock_reg <= 2'b11;
                else
                  unlock_reg <= UL_NONE;
              end
              else if (!unlocked)
              begin
                ans_cmd_reg <= `CCRA_CMD_ABORT;
                ans_word_reg <= `CCRA_AB_ACCESS;
              end
              else if (w_tbl == `CCRA_TBL_CFG && w_rg == `CCRA_REG_2)
                bus_cfg_reg <= w_val & `CCRA_BUSCFG_MASK;
              else if (w_tbl == `CCRA_TBL_CFG && w_rg == `CCRA_REG_3)
                pi_desc_reg <= w_val & `CCRA_PIDESC_MASK;
              else if (w_tbl == `CCRA_TBL_BAUD && w_rg == `CCRA_REG_3)
                baud_reg <= w_val;
              else
              begin
                ans_cmd_reg <= `CCRA_CMD_ABORT;
                ans_word_reg <= `CCRA_AB_ACCESS;
              end
            end
            else if (req_index == `CCRA_IDX_TERM)
            begin
              if (req_sub == 8'h00)
              begin
                if (is_ul)
                begin
                  ans_cmd_reg <= `CCRA_CMD_UL_ACK1;
                  ans_word_reg <= {24'h00_0000, term_count_i};
                end
                else
                begin
                  ans_cmd_reg <= `CCRA_CMD_ABORT;
                  ans_word_reg <= `CCRA_AB_RO;
                end
              end
              else if (!sub_ok || req_sub > term_count_i)
              begin
                ans_cmd_reg <= `CCRA_CMD_ABORT;
                ans_word_reg <= `CCRA_AB_NOSUB;
              end
              else if (is_ul)
              begin
                ans_cmd_reg <= `CCRA_CMD_UL_ACK;
                ans_word_reg <= {slot_busy_reg[req_sub],
                  slot_addr_reg[req_sub][30:16],
                  slot_data_reg[req_sub]};
              end
              else
              begin
                // Forward to the terminal; reply after it answers
                slot_addr_reg[req_sub] <= {1'b0, req_word[30:16],
                  16'h0000};
                slot_busy_reg[req_sub] <= ~w_acc;
                term_req_o <= 1'b1;
                term_we_o <= w_acc;
                term_slot_o <= req_sub;
                term_chan_o <= w_tbl;
                term_reg_o <= w_rg;
                term_wdata_o <= w_acc ? w_val : 16'h0000;
                pend_sub_reg <= req_sub;
                state_reg <= ST_WAIT;
              end
            end
            else
            begin
              ans_cmd_reg <= `CCRA_CMD_ABORT;
              ans_word_reg <= `CCRA_AB_NOOBJ;
            end
          end
        end
        ST_WAIT:
        begin
          if (term_ack_i)
          begin
            term_req_o <= 1'b0;
            slot_busy_reg[pend_sub_reg] <= 1'b0;
            if (!term_we_o)
              slot_data_reg[pend_sub_reg] <= term_rdata_i;
            if (term_err_i)
            begin
              ans_cmd_reg <= `CCRA_CMD_ABORT;
              ans_word_reg <= `CCRA_AB_ACCESS;
            end
            state_reg <= ST_REPLY;
          end
        end
        ST_REPLY:
        begin
          tx_valid_o <= 1'b1;
          tx_cobid_o <= `CCRA_COBID_TX | {4'h0, NODE_ID[6:0]};
          tx_data_o <= frame_out;
          state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Internal bus supervision and process image controls
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      restart_cnt_reg <= 32'h0000_0000;
      prev_fault_reg <= 1'b0;
      prev_link_reg <= 1'b0;
      int_bus_restart_o <= 1'b0;
      emcy_req_o <= 1'b0;
      diag_map_o <= 1'b0;
      zero_inputs_o <= 1'b0;
      send_zero_pdo_o <= 1'b0;
      stop_cycles_o <= 1'b0;
      zero_outputs_o <= 1'b0;
      restore_outputs_o <= 1'b0;
      word_align_o <= 1'b0;
      big_endian_o <= 1'b0;
      full_eval_o <= 1'b0;
      baud_index_o <= 4'h0;
    end
    else
    begin
      prev_fault_reg <= int_bus_fault_i;
      prev_link_reg <= link_loss_i;
      if (int_bus_fault_i && bus_cfg_reg[`CCRA_CFG_AUTORST])
        restart_cnt_reg <= restart_tick ? 32'h0000_0000 :
          restart_cnt_reg + 32'h0000_0001;
      else
        restart_cnt_reg <= 32'h0000_0000;
      int_bus_restart_o <= int_bus_fault_i &&
        bus_cfg_reg[`CCRA_CFG_AUTORST] && restart_tick;
      emcy_req_o <= term_fault_i && bus_cfg_reg[`CCRA_CFG_DIAG];
      diag_map_o <= bus_cfg_reg[`CCRA_CFG_DISP] &&
        bus_cfg_reg[`CCRA_CFG_DIAG];
      zero_inputs_o <= int_bus_fault_i &&
        (pi_desc_reg[`CCRA_PI_INT_HI:`CCRA_PI_INT_LO] ==
        `CCRA_REACT_1);
      send_zero_pdo_o <= int_bus_fault_i && !prev_fault_reg &&
        (pi_desc_reg[`CCRA_PI_INT_HI:`CCRA_PI_INT_LO] ==
        `CCRA_REACT_1);
      stop_cycles_o <= link_loss_i &&
        (pi_desc_reg[`CCRA_PI_LINK_HI:`CCRA_PI_LINK_LO] !=
        `CCRA_REACT_2);
      zero_outputs_o <= link_loss_i &&
        (pi_desc_reg[`CCRA_PI_LINK_HI:`CCRA_PI_LINK_LO] ==
        `CCRA_REACT_1);
      restore_outputs_o <= !link_loss_i && prev_link_reg &&
        (pi_desc_reg[`CCRA_PI_LINK_HI:`CCRA_PI_LINK_LO] ==
        `CCRA_REACT_0);
      word_align_o <= pi_desc_reg[`CCRA_PI_ALIGN];
      big_endian_o <= pi_desc_reg[`CCRA_PI_ORDER];
      full_eval_o <= pi_desc_reg[`CCRA_PI_EVAL];
      baud_index_o <= baud_reg[3:0];
    end
  end
endmodule // ccra_top

// [ccra_top_props.sv]
`timescale 1ns/1ps
module ccra_top_props
#(
  parameter NODE_ID = 7'h01
)
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Reply and terminal port
  input wire tx_valid_o,
  input wire [10:0] tx_cobid_o,
  input wire term_req_o,
  input wire term_we_o,
  input wire [7:0] term_slot_o,
  input wire [7:0] term_reg_o,
  input wire [15:0] term_wdata_o,
  input wire term_ack_i,
  // Status and controls
  input wire int_bus_fault_i,
  input wire link_loss_i,
  input wire term_fault_i,
  input wire int_bus_restart_o,
  input wire emcy_req_o,
  input wire zero_inputs_o,
  input wire send_zero_pdo_o,
  input wire stop_cycles_o,
  input wire zero_outputs_o,
  input wire restore_outputs_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_tx_id;
    tx_valid_o |-> tx_cobid_o == 11'h580 + NODE_ID;
  endproperty
  a_tx_id: assert property (p_tx_id)
    else $error("reply identifier wrong");
  property p_tx_pulse;
    tx_valid_o |=> !tx_valid_o;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse)
    else $error("reply longer than one cycle");
  property p_req_hold;
    term_req_o && !term_ack_i |=> term_req_o &&
      $stable({term_we_o, term_slot_o, term_reg_o, term_wdata_o});
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("terminal request dropped or changed");
  property p_slot_nz;
    term_req_o |-> term_slot_o != 8'h00;
  endproperty
  a_slot_nz: assert property (p_slot_nz)
    else $error("terminal request to slot zero");
  property p_zero_pdo;
    send_zero_pdo_o |-> zero_inputs_o && $past(int_bus_fault_i);
  endproperty
  a_zero_pdo: assert property (p_zero_pdo)
    else $error("zero message without input clearing");
  property p_zero_in;
    zero_inputs_o |-> $past(int_bus_fault_i);
  endproperty
  a_zero_in: assert property (p_zero_in)
    else $error("inputs cleared without fault");
  property p_stop;
    zero_outputs_o |-> stop_cycles_o && $past(link_loss_i);
  endproperty
  a_stop: assert property (p_stop)
    else $error("outputs zeroed without stop");
  property p_restore;
    restore_outputs_o |-> !$past(link_loss_i) && !stop_cycles_o;
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore while link still lost");
  property p_emcy;
    emcy_req_o |-> $past(term_fault_i);
  endproperty
  a_emcy: assert property (p_emcy)
    else $error("emergency without terminal fault");
  property p_restart;
    int_bus_restart_o |-> $past(int_bus_fault_i) ##1 !int_bus_restart_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart without internal fault");
endmodule // ccra_top_props

bind ccra_top ccra_top_props #(.NODE_ID(NODE_ID)) i_ccra_top_props
(
  .clk_i(clk_i),
  .rst_i(rst_i),
  .tx_valid_o(tx_valid_o),
  .tx_cobid_o(tx_cobid_o),
  .term_req_o(term_req_o),
  .term_we_o(term_we_o),
  .term_slot_o(term_slot_o),
  .term_reg_o(term_reg_o),
  .term_wdata_o(term_wdata_o),
  .term_ack_i(term_ack_i),
  .int_bus_fault_i(int_bus_fault_i),
  .link_loss_i(link_loss_i),
  .term_fault_i(term_fault_i),
  .int_bus_restart_o(int_bus_restart_o),
  .emcy_req_o(emcy_req_o),
  .zero_inputs_o(zero_inputs_o),
  .send_zero_pdo_o(send_zero_pdo_o),
  .stop_cycles_o(stop_cycles_o),
  .zero_outputs_o(zero_outputs_o),
  .restore_outputs_o(restore_outputs_o)
);

// [ccra_term_model.sv]
`timescale 1ns/1ps
module ccra_term_model
(
  input wire clk_i,
  input wire req_i,
  input wire we_i,
  input wire [7:0] reg_i,
  input wire [15:0] wdata_i,
  input wire slow_i,
  input wire fail_i,
  output reg ack_o = 1'b0,
  output reg err_o = 1'b0,
  output reg [15:0] rdata_o = 16'h5a5a
);
  reg [15:0] mem [0:255];
  reg [2:0] wait_cnt = 3'h0;
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    err_o <= 1'b0;
    // Data lines keep moving outside an answer
    rdata_o <= ~rdata_o;
    if (!req_i || ack_o)
      wait_cnt <= slow_i ? 3'h6 : 3'h0;
    else if (wait_cnt != 3'h0)
      wait_cnt <= wait_cnt - 3'h1;
    else
    begin
      ack_o <= 1'b1;
      err_o <= fail_i;
      if (we_i)
        mem[reg_i] <= wdata_i;
      else
        rdata_o <= mem[reg_i];
    end
  end
endmodule // ccra_term_model

// [ccra_top_tb_top.sv]
`timescale 1ns/1ps
module ccra_top_tb_top;
  localparam [6:0] NODE = 7'h05;
  localparam [15:0] STATION = 16'h1234; // Arbitrary value
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg rx_valid_i = 1'b0;
  reg [10:0] rx_cobid_i = 11'h000;
  reg [63:0] rx_data_i = 64'h0;
  reg [7:0] term_count_i = 8'h05;
  reg int_bus_fault_i = 1'b0;
  reg link_loss_i = 1'b0;
  reg term_fault_i = 1'b0;
  reg term_slow = 1'b0;
  reg term_fail = 1'b0;
  wire tx_valid_o, term_req_o, term_we_o, term_ack_i, term_err_i;
  wire [10:0] tx_cobid_o;
  wire [63:0] tx_data_o;
  wire [7:0] slot_sel_o, term_slot_o, term_reg_o;
  wire [6:0] term_chan_o;
  wire [15:0] term_wdata_o, term_rdata_i;
  wire int_bus_restart_o, emcy_req_o, diag_map_o, zero_inputs_o;
  wire send_zero_pdo_o, stop_cycles_o, zero_outputs_o, restore_outputs_o;
  wire word_align_o, big_endian_o, full_eval_o;
  wire [3:0] baud_index_o;
  integer error_cnt = 0;
  integer n_checks = 0;
  integer k;
  reg [7:0] rc;
  reg [31:0] rw;
  reg [1:0] code;
  reg got;
  always #5 clk_i = ~clk_i;

  ccra_top #(.NODE_ID(NODE), .STATION_ID(STATION), .RESTART_CYCLES(8))
  i_ccra_top
  (
    .clk_i(clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i),
    .rx_cobid_i(rx_cobid_i), .rx_data_i(rx_data_i),
    .tx_valid_o(tx_valid_o), .tx_cobid_o(tx_cobid_o),
    .tx_data_o(tx_data_o), .term_count_i(term_count_i),
    .slot_id_i({8'h84, 5'h00, slot_sel_o[2:0]}), .slot_sel_o(slot_sel_o),
    .term_req_o(term_req_o), .term_we_o(term_we_o),
    .term_slot_o(term_slot_o), .term_chan_o(term_chan_o),
    .term_reg_o(term_reg_o), .term_wdata_o(term_wdata_o),
    .term_ack_i(term_ack_i), .term_err_i(term_err_i),
    .term_rdata_i(term_rdata_i), .int_bus_fault_i(int_bus_fault_i),
    .link_loss_i(link_loss_i), .term_fault_i(term_fault_i),
    .int_bus_restart_o(int_bus_restart_o), .emcy_req_o(emcy_req_o),
    .diag_map_o(diag_map_o), .zero_inputs_o(zero_inputs_o),
    .send_zero_pdo_o(send_zero_pdo_o), .stop_cycles_o(stop_cycles_o),
    .zero_outputs_o(zero_outputs_o),
    .restore_outputs_o(restore_outputs_o), .word_align_o(word_align_o),
    .big_endian_o(big_endian_o), .full_eval_o(full_eval_o),
    .baud_index_o(baud_index_o)
  );

  ccra_term_model i_ccra_term_model
  (
    .clk_i(clk_i), .req_i(term_req_o), .we_i(term_we_o),
    .reg_i(term_reg_o), .wdata_i(term_wdata_o), .slow_i(term_slow),
    .fail_i(term_fail), .ack_o(term_ack_i), .err_o(term_err_i),
    .rdata_o(term_rdata_i)
  );

  task chk(input [63:0] s, input [63:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask

  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_i);
      #1;
    end
  endtask

  // One request frame, then wait for its reply
  task sdo(input [7:0] c, input [15:0] ix, input [7:0] sb, input [31:0] w);
    integer i;
    begin
      rx_cobid_i = 11'h600 + NODE;
      rx_data_i = {w, sb, ix, c};
      rx_valid_i = 1'b1;
      cyc(1);
      rx_valid_i = 1'b0;
      got = 1'b0;
      for (i = 0; i < 300 && !got; i = i + 1)
      begin
        cyc(1);
        got = (tx_valid_o === 1'b1);
      end
      chk(got, 1'b1);
      rc = tx_data_o[7:0];
      rw = tx_data_o[63:32];
    end
  endtask

  task wr(input [6:0] t, input [7:0] r, input [15:0] v);
    sdo(8'h23, 16'h4500, 8'h00, {1'b1, t, r, v});
  endtask

  // Address write, then poll until the access bit clears
  task rd(input [15:0] ix, input [7:0] sb, input [31:0] a);
    integer i;
    begin
      sdo(8'h23, ix, sb, a);
      rw = 32'h8000_0000;
      for (i = 0; i < 8 && rw[31] !== 1'b0; i = i + 1)
        sdo(8'h40, ix, sb, 32'h0000_0000);
      chk(rc, 8'h43);
    end
  endtask

  task restarts(input e);
    begin
      got = 1'b0;
      repeat (10)
      begin
        cyc(1);
        got = got | int_bus_restart_o;
      end
      chk(got, e);
    end
  endtask

  task t_defaults;
    begin
      rd(16'h4500, 8'h00, 32'h0002_beef);
      chk(rw, 32'h0002_0006);
      rd(16'h4500, 8'h00, 32'h0003_0000);
      chk(rw, 32'h0003_0903);
      chk({diag_map_o, word_align_o, big_endian_o, full_eval_o}, 4'h8);
      $display("test defaults done");
    end
  endtask

  task t_lock;
    begin
      wr(7'h00, 8'h02, 16'h0001);
      chk({rc, rw}, 40'h80_0800_0020);
      wr(7'h63, 8'h02, 16'hafff);
      wr(7'h63, 8'h01, 16'h0001);
      wr(7'h63, 8'h00, 16'h0101);
      chk(rc, 8'h60);
      wr(7'h00, 8'h02, 16'h0001);
      chk(rc, 8'h80);
      rd(16'h4500, 8'h00, 32'h0002_0000);
      chk(rw, 32'h0002_0006);
      $display("test lock done");
    end
  endtask

  task t_unlock;
    begin
      wr(7'h63, 8'h02, 16'hafff - 16'h0001);
      wr(7'h63, 8'h01, 16'h0001);
      wr(7'h63, 8'h00, 16'h0101);
      wr(7'h64, 8'h03, 16'h0007);
      chk({rc, rw}, 40'h60_0000_0000);
      cyc(1);
      chk(baud_index_o, 4'h7);
      rd(16'h4500, 8'h00, 32'h6403_0000);
      chk(rw, 32'h6403_0007);
      $display("test unlock done");
    end
  endtask

  task t_reactions;
    begin
      for (k = 0; k < 3; k = k + 1)
      begin
        code = k[1:0];
        wr(7'h00, 8'h03, 16'h042c | {6'h00, code, 8'h00});
        cyc(1);
        chk({word_align_o, big_endian_o, full_eval_o}, 3'h7);
        link_loss_i = 1'b1;
        cyc(1);
        chk({stop_cycles_o, zero_outputs_o}, {code != 2'h2, code == 2'h1});
        link_loss_i = 1'b0;
        cyc(1);
        chk(restore_outputs_o, code == 2'h0);
      end
      int_bus_fault_i = 1'b1;
      cyc(1);
      chk({zero_inputs_o, send_zero_pdo_o}, 2'h3);
      cyc(1);
      chk({zero_inputs_o, send_zero_pdo_o}, 2'h2);
      int_bus_fault_i = 1'b0;
      wr(7'h00, 8'h03, 16'h0800);
      int_bus_fault_i = 1'b1;
      cyc(2);
      chk({zero_inputs_o, word_align_o, big_endian_o}, 3'h0);
      int_bus_fault_i = 1'b0;
      $display("test reactions done");
    end
  endtask

  task t_flags;
    begin
      wr(7'h00, 8'h02, 16'h0001);
      term_fault_i = 1'b1;
      int_bus_fault_i = 1'b1;
      cyc(1);
      chk({emcy_req_o, diag_map_o}, 2'h0);
      restarts(1'b1);
      wr(7'h00, 8'h02, 16'h0006);
      cyc(1);
      chk({emcy_req_o, diag_map_o}, 2'h3);
      restarts(1'b0);
      term_fault_i = 1'b0;
      int_bus_fault_i = 1'b0;
      $display("test flags done");
    end
  endtask

  task t_ident;
    begin
      rd(16'h4500, 8'h00, 32'h0900_0000);
      chk(rw, {16'h0900, STATION});
      rd(16'h4500, 8'h00, 32'h0903_0000);
      chk(slot_sel_o, 8'h03);
      chk(rw, 32'h0903_8403);
      $display("test ident done");
    end
  endtask

  task t_terminal;
    begin
      sdo(8'h40, 16'h4501, 8'h00, 32'h0000_0000);
      chk({rc, rw[7:0]}, 16'h4f05);
      sdo(8'h23, 16'h4501, 8'h00, 32'h0000_0000);
      chk({rc, rw}, 40'h80_0601_0002);
      term_slow = 1'b1;
      sdo(8'h23, 16'h4501, 8'h05, 32'h8120_2106);
      chk({rc, term_slot_o, 1'b0, term_chan_o}, 24'h60_0501);
      rd(16'h4501, 8'h05, 32'h0120_0000);
      chk(rw, 32'h0120_2106);
      sdo(8'h23, 16'h4501, 8'h06, 32'h8120_0000);
      chk({rc, rw}, 40'h80_0609_0011);
      term_fail = 1'b1;
      sdo(8'h23, 16'h4501, 8'h02, 32'h8121_0001);
      chk(rc, 8'h80);
      term_fail = 1'b0;
      term_slow = 1'b0;
      $display("test terminal done");
    end
  endtask

  task t_refuse;
    begin
      sdo(8'h23, 16'h4600, 8'h00, 32'h0000_0000);
      chk({rc, rw}, 40'h80_0602_0000);
      sdo(8'h99, 16'h4500, 8'h00, 32'h0000_0000);
      chk({rc, rw}, 40'h80_0504_0001);
      rx_cobid_i = 11'h601 + NODE;
      rx_valid_i = 1'b1;
      cyc(1);
      rx_valid_i = 1'b0;
      cyc(1);
      chk(tx_valid_o, 1'b0);
      restarts(1'b0);
      $display("test refuse done");
    end
  endtask

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  initial
  begin
    #200000;
    error_cnt = error_cnt + 1;
    finish_test;
  end

  initial
  begin
    cyc(16);
    rst_i = 1'b0;
    t_defaults;
    t_lock;
    t_unlock;
    t_reactions;
    t_flags;
    t_ident;
    t_terminal;
    t_refuse;
    finish_test;
  end
endmodule // ccra_top_tb_top
